/* hdl/ardit_core.sv */
// digital output path: dither subtract, format, randomizer and output strobes
//
// Function
// - With scrambling on, each data bit above bit 0 is sent XORed with bit 0 of the result.
// - Scrambling leaves bit 0, the over-range flag and both strobes untouched.
// - Scrambling is applied only while the scramble select is high.
// - With dither on, a new pseudo-random value is produced for every conversion and injected.
// - With dither on, the same injected value is subtracted from that sample's result.
// - The over-range flag is high for a sample whose input left the range either way.
// - Data change as the true strobe falls and inverted strobe rises; capture on true rise.
// - Format levels ground and one-third give offset binary, two-thirds and full give two's complement.
`timescale 1ns/1ns
module ardit_core
	import ardit_pkg::*;
#(
	parameter int unsigned WIDTH = DATA_W,
	parameter int unsigned DW    = DITHER_W
) (
	// clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rstn_i,
	// static controls
	input  wire logic             output_scramble_select_i,
	input  wire logic             dither_enable_i,
	input  wire logic [1:0]       format_level_i,
	// conversion result from the pipeline
	input  wire logic             sample_valid_i,
	input  wire logic [WIDTH-1:0] raw_code_i,
	input  wire logic             raw_over_i,
	input  wire logic             raw_under_i,
	// dither value toward the dither converter
	output logic [DW-1:0]         dither_value_o,
	// output pins
	output logic [WIDTH-1:0]      data_o,
	output logic                  over_range_flag_o,
	output logic                  output_strobe_true_o,
	output logic                  output_strobe_inverted_o
);
	// only the documented word width is served; dither must leave headroom below it
	if (WIDTH != DATA_W) begin : g_bad_width
		$error("ardit_core: WIDTH must equal DATA_W");
	end
	if (DW == 0 || DW >= WIDTH) begin : g_bad_dw
		$error("ardit_core: DW must be 1..WIDTH-1");
	end

	logic [LFSR_W-1:0] prn;
	logic [DW-1:0]     dither_reg;
	logic [WIDTH-1:0]  data_reg;
	logic              ovr_reg;
	logic              strobe_reg;
	logic [WIDTH-1:0]  corrected;
	logic [WIDTH-1:0]  formatted;
	logic [WIDTH-1:0]  data_next;
	logic              twos_sel;
	logic [WIDTH:0]    diff;
	logic              strobe_inv_reg;
	logic [DW-1:0]     sub_val;

	// a fresh value each conversion; stepping only when dither is on keeps it idle otherwise
	ardit_lfsr #(
		.WIDTH (LFSR_W)
	) ardit_lfsr_inst (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.step_i     (sample_valid_i && dither_enable_i),
		.value_o    (prn)
	);

	// value presented to the dither converter for the sample now being taken
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dither_reg <= '0;
		end else if (!dither_enable_i) begin
			// turning dither off drops the pending value, so no later sample is corrected
			dither_reg <= '0;
		end else if (sample_valid_i) begin
			dither_reg <= prn[DW-1:0];
		end
	end

	assign dither_value_o = dither_reg;

	// gate the subtraction itself too; the register clears one edge late
	assign sub_val = dither_enable_i ? dither_reg : '0;

	// subtract the injected value; clamp so removal never wraps below zero
	always_comb begin
		diff = {1'b0, raw_code_i} - {{(WIDTH+1-DW){1'b0}}, sub_val};
		if (raw_over_i) begin
			corrected = CODE_MAX;
		end else if (raw_under_i || diff[WIDTH]) begin
			corrected = CODE_MIN;
		end else begin
			corrected = diff[WIDTH-1:0];
		end
	end

	// four-level format pin decoded into a two-bit code upstream
	always_comb begin
		case (ardit_fmt_t'(format_level_i))
			ARDIT_FMT_GND, ARDIT_FMT_THIRD: twos_sel = 1'b0;
			ARDIT_FMT_TWO_THD, ARDIT_FMT_FULL: twos_sel = 1'b1;
			default: twos_sel = 1'b0;
		endcase
		formatted = twos_sel ? (corrected ^ MIDSCALE) : corrected;
	end

	// randomizer; bit 0 stays plain so the far end can undo it
	always_comb begin
		data_next = formatted;
		if (output_scramble_select_i) begin
			data_next[WIDTH-1:1] = formatted[WIDTH-1:1] ^ {(WIDTH-1){formatted[0]}};
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			data_reg <= '0;
			ovr_reg  <= 1'b0;
		end else if (sample_valid_i) begin
			data_reg <= data_next;
			ovr_reg  <= raw_over_i || raw_under_i;
		end
	end

	// strobe drops with each data update and rises the first cycle without a sample, mid-window
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strobe_reg <= 1'b1;
		end else begin
			strobe_reg <= !sample_valid_i;
		end
	end

	// own flop for the inverted strobe so both pins leave a register on the same edge
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strobe_inv_reg <= 1'b0;
		end else begin
			strobe_inv_reg <= sample_valid_i;
		end
	end

	assign data_o                   = data_reg;
	assign over_range_flag_o        = ovr_reg;
	assign output_strobe_true_o     = strobe_reg;
	assign output_strobe_inverted_o = strobe_inv_reg;

	// randomizer and pass-through
	a_scramble_bits: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		sample_valid_i && output_scramble_select_i |=>
		data_o[WIDTH-1:1] == ($past(formatted[WIDTH-1:1]) ^ {(WIDTH-1){$past(formatted[0])}}))
		else $error("scrambled bits wrong");
	a_scramble_undo: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		sample_valid_i && output_scramble_select_i |=>
		(data_o ^ {{(WIDTH-1){data_o[0]}}, 1'b0}) == $past(formatted))
		else $error("scrambled word not reversible");
	a_lsb_plain: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		sample_valid_i |=> data_o[0] == $past(formatted[0]))
		else $error("lsb altered");
	a_plain_word: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		sample_valid_i && !output_scramble_select_i |=> data_o == $past(formatted))
		else $error("plain word altered");

	// dither injection and removal
	a_dither_sub: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!raw_over_i && !raw_under_i && !diff[WIDTH] |->
		corrected + {{(WIDTH-DW){1'b0}}, sub_val} == raw_code_i)
		else $error("dither not removed");
	a_no_dither_off: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		sample_valid_i && !dither_enable_i |=> dither_value_o == '0)
		else $error("dither active while off");
	a_no_sub_off: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!dither_enable_i && !raw_over_i && !raw_under_i |-> corrected == raw_code_i)
		else $error("subtraction active while off");
	a_dither_fresh: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		sample_valid_i && dither_enable_i |=> dither_value_o == $past(prn[DW-1:0]))
		else $error("dither value not from generator");
	a_prn_idle: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!(sample_valid_i && dither_enable_i) |=> $stable(prn))
		else $error("generator stepped without a dithered sample");

	// clamping at the ends of the code range
	a_clamp_over: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		raw_over_i |-> corrected == CODE_MAX)
		else $error("over-range not clamped high");
	a_clamp_under: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!raw_over_i && raw_under_i |-> corrected == CODE_MIN)
		else $error("under-range not clamped low");
	a_over_flag: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		sample_valid_i |=> over_range_flag_o == $past(raw_over_i || raw_under_i))
		else $error("over-range flag wrong");

	// strobe pair: low for the update cycle, back high after a lone sample
	sequence s_update;
		sample_valid_i ##1 !output_strobe_true_o && output_strobe_inverted_o;
	endsequence
	sequence s_single;
		sample_valid_i ##1 !sample_valid_i;
	endsequence
	sequence s_release;
		output_strobe_true_o && !output_strobe_inverted_o;
	endsequence
	a_strobe_edge: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		sample_valid_i |-> s_update)
		else $error("strobe not low at update");
	a_strobe_release: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		s_single |=> s_release)
		else $error("strobe did not rise after update");
	a_strobe_pair: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		output_strobe_true_o != output_strobe_inverted_o)
		else $error("strobes not complementary");
	a_data_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!sample_valid_i |=> $stable(data_o) && $stable(over_range_flag_o))
		else $error("outputs changed without a sample");

	// output format
	a_format_twos: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		format_level_i[1] |-> formatted[WIDTH-1] == !corrected[WIDTH-1])
		else $error("format not two's complement");
	a_format_low: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		format_level_i[1] |-> formatted[WIDTH-2:0] == corrected[WIDTH-2:0])
		else $error("two's complement low bits altered");
	a_format_offset: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!format_level_i[1] |-> formatted == corrected)
		else $error("offset binary altered");
endmodule

/* shared/ardit_pkg.sv */
// constants and types shared by the output randomizer and dither path
package ardit_pkg;
	localparam int unsigned DATA_W     = 14;
	localparam int unsigned LFSR_W     = 23;
	localparam int unsigned DITHER_W   = 8;
	localparam logic [22:0] LFSR_SEED  = 23'h000001;
	localparam logic [22:0] LFSR_TAPS  = 23'h420000;
	localparam logic [13:0] MIDSCALE   = 14'h2000;
	localparam logic [13:0] CODE_MAX   = 14'h3FFF;
	localparam logic [13:0] CODE_MIN   = 14'h0000;
	localparam int unsigned STROBE_HALF_CYC = 1;

	typedef enum logic [1:0] {
		ARDIT_FMT_GND     = 2'b00,
		ARDIT_FMT_THIRD   = 2'b01,
		ARDIT_FMT_TWO_THD = 2'b10,
		ARDIT_FMT_FULL    = 2'b11
	} ardit_fmt_t;

	typedef enum logic [0:0] {
		ARDIT_PH_UPDATE = 1'b0,
		ARDIT_PH_HOLD   = 1'b1
	} ardit_phase_t;
endpackage

/* hdl/ardit_lfsr.sv */
// galois pseudo-random source, one step per dithered conversion
`timescale 1ns/1ns
module ardit_lfsr
	import ardit_pkg::*;
#(
	parameter int unsigned WIDTH = LFSR_W
) (
	// clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rstn_i,
	// control
	input  wire logic             step_i,
	// state
	output logic [WIDTH-1:0]      value_o
);
	// taps and seed are fixed for one length only
	if (WIDTH != LFSR_W) begin : g_bad_width
		$error("ardit_lfsr: WIDTH must equal LFSR_W");
	end

	logic [WIDTH-1:0] state_reg;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= LFSR_SEED;
		end else if (step_i) begin
			// maximal length taps, never locks up since zero is unreachable
			state_reg <= {1'b0, state_reg[WIDTH-1:1]} ^ (state_reg[0] ? LFSR_TAPS : '0);
		end
	end

	assign value_o = state_reg;

	a_lfsr_advance: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		step_i |=> state_reg != $past(state_reg)) else $error("lfsr did not advance");
	a_lfsr_nonzero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		state_reg != '0) else $error("lfsr reached zero");
endmodule

/* test/ardit_capture_model.sv */
// capture-side model: latches on the true strobe rise and undoes the scrambling
`timescale 1ns/1ns
module ardit_capture_model (
	// pins from the device
	input  wire logic [13:0] data_i,
	input  wire logic        flag_i,
	input  wire logic        strobe_true_i,
	input  wire logic        scramble_i,
	// recovered sample
	output logic [13:0]      word_o,
	output logic             flag_o
);
	// bit 0 is sent plain, so it alone can key the undo
	always_ff @(posedge strobe_true_i) begin
		word_o <= scramble_i ? data_i ^ {{13{data_i[0]}}, 1'b0} : data_i;
		flag_o <= flag_i;
	end
endmodule

/* test/ardit_core_tb_top.sv */
// self-checking bench for the output randomizer and dither path
`timescale 1ns/1ns
module ardit_core_tb_top;
	import ardit_pkg::*;
	logic        core_clk_i, rstn_i, scr, dit, val, ovr, und, flag, st, sti, cflag;
	logic [1:0]  fmt;
	logic [13:0] raw, data, word;
	logic [7:0]  dv, d;
	int          err_count, num_checks, cyc, nchg;
	ardit_core ardit_core_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.output_scramble_select_i(scr), .dither_enable_i(dit), .format_level_i(fmt),
		.sample_valid_i(val), .raw_code_i(raw), .raw_over_i(ovr), .raw_under_i(und),
		.dither_value_o(dv), .data_o(data), .over_range_flag_o(flag),
		.output_strobe_true_o(st), .output_strobe_inverted_o(sti));
	ardit_capture_model ardit_capture_model_inst (.data_i(data), .flag_i(flag),
		.strobe_true_i(st), .scramble_i(scr), .word_o(word), .flag_o(cflag));
	task automatic chk_word(input logic [13:0] g, input logic [13:0] e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %0t word %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %0t bit %b expected %b", $time, g, e);
		end
	endtask
	// one conversion, entered and left at a falling edge
	task automatic conv(input logic [13:0] r, input logic o, input logic u);
		logic [13:0] p;
		d = dit ? dv : 8'h00;
		p = o ? CODE_MAX : u ? CODE_MIN : (r < 14'(d)) ? CODE_MIN : r - 14'(d);
		p[13] = p[13] ^ fmt[1];
		raw = r;
		ovr = o;
		und = u;
		val = 1'b1;
		@(negedge core_clk_i);
		val = 1'b0;
		chk_word(data, scr ? p ^ {{13{p[0]}}, 1'b0} : p);
		chk_bit(flag, o | u);
		chk_bit(st, 1'b0);
		chk_bit(sti, 1'b1);
		@(negedge core_clk_i);
		chk_bit(st, 1'b1);
		chk_word(word, p);
		chk_bit(cflag, o | u);
		if (dv !== d) nchg++;
	endtask
	task automatic t_formats(input logic s);
		scr = s;
		for (int i = 0; i < 4; i++) begin
			fmt = 2'(i);
			conv(14'h2A5B, 1'b0, 1'b0);
			conv(14'h1234, 1'b0, 1'b0);
		end
		$display("format test done, scramble %b", s);
	endtask
	task automatic t_range();
		conv(14'h1111, 1'b1, 1'b0);
		conv(14'h1111, 1'b0, 1'b1);
		conv(14'h1111, 1'b0, 1'b0);
		$display("range test done");
	endtask
	task automatic t_dither();
		dit = 1'b1;
		nchg = 0;
		for (int i = 0; i < 24; i++) conv(MIDSCALE + 14'(i * 291), 1'b0, 1'b0);
		conv(14'h0001, 1'b0, 1'b0);
		chk_bit(nchg > 0, 1'b1);
		$display("dither test done");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	// the whole run needs about 100 cycles
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			test_done();
		end
	end
	initial begin
		{rstn_i, scr, dit, val, ovr, und, fmt, raw} = '0;
		repeat (6) @(negedge core_clk_i);
		rstn_i = 1'b1;
		t_formats(1'b0);
		t_formats(1'b1);
		t_range();
		fmt = 2'b00;
		t_dither();
		dit = 1'b0;
		nchg = 0;
		conv(14'h0F0F, 1'b0, 1'b0);
		chk_bit(dv === 8'h00, 1'b1);
		conv(14'h0005, 1'b0, 1'b0);
		chk_bit(nchg == 0, 1'b1);
		$display("dither off test done");
		test_done();
	end
endmodule
